//--- inc/step_skip_pkg.sv
package step_skip_pkg;
    localparam int OPCODE_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int FILE_ADDR_WIDTH = 5;
    localparam logic [6:0] OPC_STEP_DOWN = 7'h16;
    localparam logic [6:0] OPC_STEP_UP = 7'h1e;
    localparam logic [11:0] OPC_IDLE = 12'h000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FILE_ADDR_RESET = 5'h00;

    typedef enum {
        OP_OTHER,
        OP_STEP_DOWN,
        OP_STEP_UP,
        OP_IDLE
    } instr_kind_e;

    typedef struct packed {
        logic valid;
        logic [11:0] opcode;
    } fetch_s;

    typedef struct packed {
        logic accWrite;
        logic [7:0] accData;
        logic skip;
    } result_s;
endpackage

//--- rtl/step_skip_decode.sv
`timescale 1ns/10ps
module step_skip_decode
    import step_skip_pkg::*;
(
    input wire logic [11:0] opcode,
    output instr_kind_e kind,
    output logic [4:0] fileAddr
);
    always_comb begin
        fileAddr = opcode[4:0];
        if (opcode[11:5] == OPC_STEP_DOWN) begin
            kind = OP_STEP_DOWN;
        end else if (opcode[11:5] == OPC_STEP_UP) begin
            kind = OP_STEP_UP;
        end else if (opcode == OPC_IDLE) begin
            kind = OP_IDLE;
        end else begin
            kind = OP_OTHER;
        end
    end
endmodule

//--- rtl/step_move_skip_zero.sv
`timescale 1ns/10ps
module step_move_skip_zero
    import step_skip_pkg::*;
#(
    parameter int DATA_W = DATA_WIDTH,
    parameter int ADDR_W = FILE_ADDR_WIDTH,
    parameter int OP_W = OPCODE_WIDTH
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire fetch_s fetch,
    input wire logic [7:0] fileData,
    output logic [4:0] fileAddr,
    output logic [7:0] acc,
    output result_s result,
    output logic annulled,
    output logic instrDone
);
    instr_kind_e kind;
    logic [4:0] decAddr;
    logic [7:0] stepped;
    logic consumed;
    logic executes;
    logic stepping;
    logic [7:0] acc_q, acc_d;
    result_s result_q, result_d;
    logic skipPending_q, skipPending_d;
    logic annulled_q, annulled_d;
    logic instrDone_q, instrDone_d;

    // The package carriers fix these widths, so only the defaults can be served
    if (DATA_W != DATA_WIDTH) begin : g_bad_data
        $error("DATA_W must match the accumulator width");
    end

    if (ADDR_W != FILE_ADDR_WIDTH) begin : g_bad_addr
        $error("ADDR_W must match the operand field width");
    end

    if (OP_W != OPCODE_WIDTH) begin : g_bad_op
        $error("OP_W must match the instruction word width");
    end

    // Zero test shared by the skip tracker and the result carrier
    function automatic logic isZero(input logic [7:0] value);
        return (value == 8'h00);
    endfunction

    // Only the two stepping instructions load the accumulator here
    function automatic logic isStep(input instr_kind_e k);
        return (k == OP_STEP_DOWN) || (k == OP_STEP_UP);
    endfunction

    // Eight-bit arithmetic: all ones plus one wraps to zero on purpose
    function automatic logic [7:0] stepValue(input instr_kind_e k, input logic [7:0] value);
        logic [7:0] out;
        out = value;
        if (k == OP_STEP_DOWN) begin
            out = value - 8'h01;
        end else if (k == OP_STEP_UP) begin
            out = value + 8'h01;
        end
        return out;
    endfunction

    step_skip_decode u_decode (
        .opcode(fetch.opcode),
        .kind(kind),
        .fileAddr(decAddr)
    );

    // Operand is read combinationally from the addressed file register.
    // Registering the address would cost a cycle per instruction, so this
    // one output is left combinational.
    assign fileAddr = decAddr;

    // Shared qualifiers for every group below
    always_comb begin
        consumed = fetch.valid;
        executes = fetch.valid && !skipPending_q;
        stepping = executes && isStep(kind);
        stepped = stepValue(kind, fileData);
    end

    // Skip tracker: a zero result owes the next fetched word
    always_comb begin
        skipPending_d = skipPending_q;
        if (consumed && skipPending_q) begin
            // Skipped word is fetched but burns its cycle with no effect
            skipPending_d = 1'b0;
        end else if (stepping) begin
            skipPending_d = isZero(stepped);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            skipPending_q <= 1'b0;
        end else begin
            skipPending_q <= skipPending_d;
        end
    end

    // Accumulator: idle, other and annulled words leave it alone
    always_comb begin
        acc_d = acc_q;
        if (stepping) begin
            acc_d = stepped;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Result carrier: one-cycle pulse after a stepping word.
    // Status flags live outside this block and are never touched.
    always_comb begin
        result_d = '0;
        if (stepping) begin
            result_d.accWrite = 1'b1;
            result_d.accData = stepped;
            result_d.skip = isZero(stepped);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    // Progress pulses: one per consumed word, annulled ones included
    always_comb begin
        annulled_d = consumed && skipPending_q;
        instrDone_d = consumed;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            annulled_q <= 1'b0;
            instrDone_q <= 1'b0;
        end else begin
            annulled_q <= annulled_d;
            instrDone_q <= instrDone_d;
        end
    end

    assign acc = acc_q;
    assign result = result_q;
    assign annulled = annulled_q;
    assign instrDone = instrDone_q;
endmodule

//--- bench/step_move_skip_zero_props.sv
`timescale 1ns/10ps
module step_move_skip_zero_props
    import step_skip_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire fetch_s fetch,
    input wire logic [7:0] fileData,
    input wire logic [4:0] fileAddr,
    input wire logic [7:0] acc,
    input wire result_s result,
    input wire logic annulled,
    input wire logic instrDone
);
    logic pendQ;
    logic pendD;
    logic live;
    // A skip stays owed across fetch gaps
    always_comb pendD = resetn && (result.skip || pendQ) && !fetch.valid;
    always_ff @(posedge clk) pendQ <= pendD;
    assign live = fetch.valid && !(result.skip || pendQ);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    step_down_a: assert property (live && fetch.opcode[11:5] == OPC_STEP_DOWN
        |=> result.accWrite && acc == $past(fileData) - 8'h01) else $error("step down");
    step_up_a: assert property (live && fetch.opcode[11:5] == OPC_STEP_UP
        |=> result.accWrite && acc == $past(fileData) + 8'h01) else $error("step up");
    zero_skip_a: assert property (result.accWrite |-> result.skip == (acc == 8'h00))
        else $error("zero skip");
    annul_word_a: assert property (fetch.valid && !live |=> annulled && $stable(acc))
        else $error("annul");
    idle_word_a: assert property (live && fetch.opcode == OPC_IDLE
        |=> instrDone && !result.accWrite && $stable(acc)) else $error("idle");
    file_addr_a: assert property (fileAddr == fetch.opcode[4:0]) else $error("addr");
    word_done_a: assert property (1'b1 |=> instrDone == $past(fetch.valid))
        else $error("done");
endmodule
bind step_move_skip_zero step_move_skip_zero_props u_props (.clk, .resetn, .fetch,
    .fileData, .fileAddr, .acc, .result, .annulled, .instrDone);

//--- bench/step_move_skip_zero_tb.sv
`timescale 1ns/10ps
module step_move_skip_zero_tb;
    import step_skip_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    fetch_s fetch = '0;
    logic [7:0] fileData = 8'h00;
    logic [4:0] fileAddr;
    logic [7:0] acc;
    result_s result;
    logic annulled;
    logic instrDone;
    int err_total = 0;
    int checks_done = 0;
    step_move_skip_zero u_dut (.clk(clk), .resetn(resetn), .fetch(fetch), .fileData(fileData),
        .fileAddr(fileAddr), .acc(acc), .result(result), .annulled(annulled),
        .instrDone(instrDone));
    initial forever #25 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic issue(input logic [11:0] op, input logic [7:0] fd);
        @(posedge clk);
        fetch <= '{valid: 1'b1, opcode: op};
        fileData <= fd;
    endtask
    // Second word is a step so an annul that leaks shows up in acc
    task automatic step_pair(input logic [11:0] op, input logic [7:0] fd, input logic [7:0] expAcc,
        input logic sk);
        logic wr;
        wr = (op[11:5] == OPC_STEP_DOWN) || (op[11:5] == OPC_STEP_UP);
        issue(op, fd);
        issue({OPC_STEP_DOWN, 5'h03}, 8'h33);
        #1;
        chk("acc", expAcc, acc);
        chk("skip", {7'h00, sk}, {7'h00, result.skip});
        chk("accWrite", {7'h00, wr}, {7'h00, result.accWrite});
        chk("accData", wr ? expAcc : 8'h00, result.accData);
        chk("fileAddr", 8'h03, {3'h0, fileAddr});
        issue(OPC_IDLE, 8'h00);
        #1;
        chk("annulled", {7'h00, sk}, {7'h00, annulled});
        chk("done", 8'h01, {7'h00, instrDone});
        chk("acc next", sk ? expAcc : 8'h32, acc);
    endtask
    // Reset in mid-run while a skip is owed must drop the owed skip
    task automatic t_reset_mid;
        issue({OPC_STEP_UP, 5'h01}, 8'hff);
        @(posedge clk);
        resetn <= 1'b0;
        fetch <= '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("acc reset", ACC_RESET, acc);
        chk("done reset", 8'h00, {7'h00, instrDone});
        issue({OPC_STEP_DOWN, 5'h02}, 8'h10);
        @(posedge clk);
        #1;
        chk("annul after reset", 8'h00, {7'h00, annulled});
        chk("acc after reset", 8'h0f, acc);
    endtask
    task automatic t_other; step_pair(12'h2a5, 8'h01, 8'h32, 1'b0); endtask
    task automatic t_down; step_pair({OPC_STEP_DOWN, 5'h1f}, 8'h75, 8'h74, 1'b0); endtask
    task automatic t_down_zero; step_pair({OPC_STEP_DOWN, 5'h0a}, 8'h01, 8'h00, 1'b1); endtask
    task automatic t_up; step_pair({OPC_STEP_UP, 5'h11}, 8'h75, 8'h76, 1'b0); endtask
    task automatic t_up_wrap; step_pair({OPC_STEP_UP, 5'h1f}, 8'hff, 8'h00, 1'b1); endtask
    task automatic t_idle; step_pair(OPC_IDLE, 8'h55, 8'h32, 1'b0); endtask
    task automatic finish_test;
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("acc after start", ACC_RESET, acc);
        t_down();
        t_down_zero();
        t_up();
        t_idle();
        t_other();
        t_up_wrap();
        t_reset_mid();
        finish_test();
    end
endmodule
